// >>> tweep_chk.sv
// Checker of the two-wire link between the controller and memory ends
module tweep_chk
  import tweep_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda_dev_oe,
  input wire logic sda_host_oe,
  input wire logic sda_in
);
  logic scl_d, sda_d, framed, acked0, rise, start, stop;
  logic [3:0] pos, pos_now;
  logic [7:0] word;
  logic [8:0] nbyte;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Bus conditions seen from the system clock; pos_now avoids a lag of one
  assign rise = scl && !scl_d;
  assign start = scl && scl_d && sda_d && !sda_in;
  assign stop = scl && scl_d && !sda_d && sda_in;
  assign pos_now = rise ? ((pos == 4'h9) ? 4'h1 : pos + 4'h1) : pos;
  // Delayed copies of the wires, idle level during reset
  always_ff @(posedge sys_clk)
  begin
    scl_d <= sys_rst ? 1'b1 : scl;
    sda_d <= sys_rst ? 1'b1 : sda_in;
  end
  // Bit position, byte index and captured word within a frame
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || start)
    begin
      pos <= 4'h0;
      nbyte <= 9'h000;
      word <= 8'h00;
    end
    else if (rise)
    begin
      pos <= pos_now;
      if (pos == 4'h9)
        nbyte <= nbyte + 9'h001;
      if (pos_now <= 4'h8)
        word <= {word[6:0], sda_in};
    end
  end
  // Frame flag and whether the device word was acknowledged
  always_ff @(posedge sys_clk)
  begin
    framed <= !sys_rst && (start || (framed && !stop));
    if (sys_rst || start)
      acked0 <= 1'b0;
    else if (scl && pos_now == 4'h9 && nbyte == 9'h000 && sda_dev_oe)
      acked0 <= 1'b1;
  end
  sequence s_ack_hold;
    sda_dev_oe [*4];
  endsequence
  sequence s_scl_drop;
    ##[1:10] !scl;
  endsequence
  AST_DEV_EDGE: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device moved sda while scl high");
  AST_ACK_HOLD: assert property (rise && sda_dev_oe |-> s_ack_hold)
    else $error("device ack not held over scl high");
  AST_ACK_SLOT: assert property (scl && sda_dev_oe |-> pos_now == 4'h9)
    else $error("device drove sda outside ninth clock");
  AST_IDLE_FREE: assert property (!framed |-> !sda_dev_oe)
    else $error("device drove sda outside a frame");
  AST_CLASS: assert property (scl && pos_now == 4'h9 && nbyte == 9'h000
    && sda_dev_oe |-> word[7:4] == TWEEP_CLASS_CODE)
    else $error("device acked a foreign class code");
  AST_LATER_ACK: assert property (scl && pos_now == 4'h9
    && nbyte != 9'h000 && acked0 |-> sda_dev_oe)
    else $error("device missed ack of a later byte");
  AST_STOP_FREE: assert property (stop |-> !sda_dev_oe ##1 !sda_dev_oe)
    else $error("device held sda at stop");
  AST_START_SCL: assert property (start |-> s_scl_drop)
    else $error("scl not lowered after start");
endmodule

// >>> tweep_device.sv
// Memory end: two-wire target with write path, polling and protection
// Functional notes
// - Sample on SCL rise, shift after fall
// - SDA only pulled low or released
// - Unconnected chip selects read as low
// - Write protect high blocks all programming
// - SDA changes only while SCL low
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - Standby on read STOP, or after programming
// - Acknowledge each byte on ninth clock
// - Standby after reset, read STOP, programming
// - Top four address bits must match class
// - Chip-select bits match pins, else standby
// - Seventh address bit is page select
// - Seventeen-bit address, 512 pages of 256
// - Last address bit chooses read or write
// - Byte write: address, two bytes, data, STOP
// - Self-timed programming ignores all inputs
// - Up to 255 more page bytes
// - Page writes increment only low eight address bits
// - No acknowledge while programming; polling works
// - Address counter keeps last address plus one
// - New START aborts pending write; here only the programming cycle is cancelled, bytes already stored in mem stay
module tweep_device
  import tweep_pkg::*;
#(
  parameter int PROG_CYCLES = TWEEP_PROG_CYCLES,
  parameter int PAGE_BYTES = 256
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  tweep_link_if.device link,
  input wire logic chip_select_upper_pin,
  input wire logic chip_select_lower_pin,
  input wire logic write_protect,
  output logic busy,
  output logic addressed
);
  initial
  begin
    if (PROG_CYCLES < 1 || PAGE_BYTES != (1 << TWEEP_PAGE_W))
      $error("tweep_device: unsupported parameters");
  end

  // Link-domain state, clocked by SCL rise/fall and SDA edges
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [2:0] phase_reg; // 0 devaddr,1 hi,2 lo,3 data,4 read,5 ignore
  logic ack_reg;
  logic sda_oe_reg;
  logic rd_mode_reg;
  logic [7:0] rd_byte_reg;
  tweep_addr_t addr_reg;
  logic [7:0] mem [0:(1<<TWEEP_ADDR_W)-1];
  logic start_tgl_reg;
  logic stop_tgl_reg;
  logic wrote_reg;
  logic start_seen;
  logic stop_seen;

  // Busy as seen in the link domain, via two flops
  logic busy_l1_reg;
  logic busy_l2_reg;
  // Start/stop toggles crossing into the system domain
  logic start_s1_reg, start_s2_reg, start_s3_reg;
  logic stop_s1_reg, stop_s2_reg, stop_s3_reg;
  logic prog_pend_tgl_reg;
  logic pend_s1_reg, pend_s2_reg, pend_s3_reg;
  logic [31:0] prog_cnt_reg;

  function automatic logic sel_match(input logic [7:0] b);
    // Floating pins arrive here already pulled low by the pad
    sel_match = b[7:4] == TWEEP_CLASS_CODE
      && b[TWEEP_SEL_UPPER_POS] == chip_select_upper_pin
      && b[TWEEP_SEL_LOWER_POS] == chip_select_lower_pin;
  endfunction

  // START: SDA falls while SCL is high
  always_ff @(negedge link.sda_in or posedge sys_rst)
  begin
    if (sys_rst)
      start_tgl_reg <= 1'b0;
    else if (link.scl)
      start_tgl_reg <= ~start_tgl_reg;
  end

  // STOP: SDA rises while SCL is high
  always_ff @(posedge link.sda_in or posedge sys_rst)
  begin
    if (sys_rst)
      stop_tgl_reg <= 1'b0;
    else if (link.scl)
      stop_tgl_reg <= ~stop_tgl_reg;
  end

  // Bus condition seen since the last SCL rise
  logic start_ack_reg, stop_ack_reg;
  assign start_seen = start_tgl_reg != start_ack_reg;
  assign stop_seen = stop_tgl_reg != stop_ack_reg;

  // Receive side: sample SDA on SCL rise
  always_ff @(posedge link.scl or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      start_ack_reg <= 1'b0;
      stop_ack_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      phase_reg <= 3'h5;
      ack_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
      addr_reg <= '0;
      wrote_reg <= 1'b0;
      busy_l1_reg <= 1'b0;
      busy_l2_reg <= 1'b0;
      prog_pend_tgl_reg <= 1'b0;
    end
    else
    begin
      busy_l1_reg <= busy;
      busy_l2_reg <= busy_l1_reg;
      start_ack_reg <= start_tgl_reg;
      stop_ack_reg <= stop_tgl_reg;
      ack_reg <= 1'b0;
      if (stop_seen && wrote_reg && !write_protect)
        prog_pend_tgl_reg <= ~prog_pend_tgl_reg;
      if (stop_seen)
      begin
        wrote_reg <= 1'b0;
        phase_reg <= 3'h5;
      end
      if (start_seen)
      begin
        // A new command cancels programming of an unfinished write; bytes already in mem stay
        wrote_reg <= 1'b0;
        phase_reg <= 3'h0;
        bit_cnt_reg <= 4'h1;
        shift_reg <= {7'h00, link.sda_in};
      end
      else if (phase_reg != 3'h5 && !busy_l2_reg)
      begin
        if (bit_cnt_reg == 4'h8)
        begin
          bit_cnt_reg <= 4'h0; // ninth clock
        end
        else
        begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          shift_reg <= {shift_reg[6:0], link.sda_in};
        end
        if (bit_cnt_reg == 4'h7)
        begin
          // Full byte now in shift_reg plus this bit
          case (phase_reg)
            3'h0:
            begin
              if (sel_match({shift_reg[6:0], link.sda_in}))
              begin
                ack_reg <= 1'b1;
                rd_mode_reg <= link.sda_in;
                addr_reg[16] <= shift_reg[0];
                phase_reg <= link.sda_in ? 3'h4 : 3'h1;
              end
              else
                phase_reg <= 3'h5;
            end
            3'h1:
            begin
              ack_reg <= 1'b1;
              addr_reg[15:8] <= {shift_reg[6:0], link.sda_in};
              phase_reg <= 3'h2;
            end
            3'h2:
            begin
              ack_reg <= 1'b1;
              addr_reg[7:0] <= {shift_reg[6:0], link.sda_in};
              phase_reg <= 3'h3;
            end
            3'h3:
            begin
              ack_reg <= 1'b1;
              if (!write_protect)
                mem[addr_reg] <= {shift_reg[6:0], link.sda_in};
              wrote_reg <= 1'b1;
              addr_reg[7:0] <= addr_reg[7:0] + 8'h01;
            end
            3'h4:
            begin
              addr_reg <= addr_reg + 17'h00001;
            end
            default:
              phase_reg <= 3'h5;
          endcase
        end
        if (phase_reg == 3'h4 && bit_cnt_reg == 4'h8 && link.sda_in)
          phase_reg <= 3'h5; // Controller declined more read data
      end
    end
  end

  // Read data fetched at the current address
  always_comb rd_byte_reg = mem[addr_reg];

  // Drive side: update SDA only after SCL falls
  always_ff @(negedge link.scl or posedge sys_rst)
  begin
    if (sys_rst)
      sda_oe_reg <= 1'b0;
    else if (ack_reg)
      sda_oe_reg <= 1'b1;
    else if (phase_reg == 3'h4 && rd_mode_reg && bit_cnt_reg != 4'h8
             && !busy_l2_reg)
      sda_oe_reg <= !rd_byte_reg[3'd7 - bit_cnt_reg[2:0]];
    else
      sda_oe_reg <= 1'b0;
  end
  assign link.sda_dev_oe = sda_oe_reg;

  // Programming request, START and STOP toggles into the system domain
  always_ff @(posedge sys_clk)
  begin
    pend_s1_reg <= prog_pend_tgl_reg;
    pend_s2_reg <= pend_s1_reg;
    pend_s3_reg <= pend_s2_reg;
    start_s1_reg <= start_tgl_reg;
    start_s2_reg <= start_s1_reg;
    start_s3_reg <= start_s2_reg;
    stop_s1_reg <= stop_tgl_reg;
    stop_s2_reg <= stop_s1_reg;
    stop_s3_reg <= stop_s2_reg;
  end

  // Self-timed write cycle; busy withholds acknowledges
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      prog_cnt_reg <= 32'h00000000;
      busy <= 1'b0;
    end
    else if (pend_s2_reg != pend_s3_reg)
    begin
      prog_cnt_reg <= 32'(PROG_CYCLES);
      busy <= 1'b1;
    end
    else if (busy)
    begin
      prog_cnt_reg <= prog_cnt_reg - 32'h00000001;
      if (prog_cnt_reg == 32'h00000001)
        busy <= 1'b0;
    end
  end

  // Addressed flag for observation: set by START, cleared by STOP
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      addressed <= 1'b0;
    else if (start_s2_reg != start_s3_reg)
      addressed <= 1'b1;
    else if (stop_s2_reg != stop_s3_reg)
      addressed <= 1'b0;
  end
endmodule

// >>> tweep_host.sv
// Controller end: issues byte writes, address-only writes and address polls
module tweep_host
  import tweep_pkg::*;
#(
  parameter int HALF = TWEEP_SCL_HALF
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  tweep_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_dev,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic [1:0] cmd_len,
  output logic cmd_ready,
  output logic cmd_nack
);
  initial
  begin
    if (HALF < 2)
      $error("tweep_host: HALF too small");
  end

  tweep_host_e state_reg;
  logic [7:0] div_reg;
  logic phase_reg;
  logic scl_reg;
  logic sda_oe_reg;
  logic [7:0] tx_reg;
  logic [3:0] bit_reg;
  logic [1:0] left_reg;
  logic [7:0] b1_reg, b2_reg, b3_reg;
  logic ack_s1_reg, ack_s2_reg;

  // SDA crosses from the wire through two flops
  always_ff @(posedge sys_clk)
  begin
    ack_s1_reg <= link.sda_in;
    ack_s2_reg <= ack_s1_reg;
  end

  wire tick = div_reg == 8'(HALF - 1);

  // Divider: SCL derived from sys_clk, each step one half period
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || state_reg == TWEEP_IDLE)
      div_reg <= 8'h00;
    else
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
  end

  // Sequencer: START, bytes with ninth clock, STOP
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= TWEEP_IDLE;
      scl_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
      phase_reg <= 1'b0;
      cmd_ready <= 1'b1;
      cmd_nack <= 1'b0;
      bit_reg <= 4'h0;
      left_reg <= 2'h0;
      tx_reg <= 8'h00;
    end
    else
      case (state_reg)
        TWEEP_IDLE:
          if (cmd_valid)
          begin
            cmd_ready <= 1'b0;
            cmd_nack <= 1'b0;
            tx_reg <= cmd_dev;
            b1_reg <= cmd_addr[15:8];
            b2_reg <= cmd_addr[7:0];
            b3_reg <= cmd_data;
            left_reg <= cmd_len;
            state_reg <= TWEEP_START;
          end
        TWEEP_START:
          if (tick)
          begin
            sda_oe_reg <= 1'b1; // START while SCL high
            bit_reg <= 4'h0;
            phase_reg <= 1'b0;
            state_reg <= TWEEP_BITS;
          end
        TWEEP_BITS:
          if (tick)
          begin
            phase_reg <= ~phase_reg;
            if (!phase_reg)
            begin
              scl_reg <= 1'b0;
            end
            else if (scl_reg == 1'b0 && bit_reg[3] == 1'b0 &&
                     div_reg == 8'(HALF - 1))
            begin
              scl_reg <= 1'b1;
            end
            // Data placed only while SCL is low
            if (!phase_reg && bit_reg != 4'h8)
              sda_oe_reg <= !tx_reg[7];
            else if (!phase_reg)
              sda_oe_reg <= 1'b0;
            if (phase_reg)
            begin
              scl_reg <= 1'b1;
              if (bit_reg == 4'h8)
                state_reg <= TWEEP_ACK;
              else
              begin
                bit_reg <= bit_reg + 4'h1;
                tx_reg <= {tx_reg[6:0], 1'b0};
              end
            end
          end
        TWEEP_ACK:
          if (tick)
          begin
            scl_reg <= 1'b0;
            bit_reg <= 4'h0;
            if (ack_s2_reg || left_reg == 2'h0)
            begin
              cmd_nack <= ack_s2_reg;
              sda_oe_reg <= 1'b1; // Hold low to build STOP
              state_reg <= TWEEP_STOP;
            end
            else
            begin
              left_reg <= left_reg - 2'h1;
              tx_reg <= b1_reg;
              b1_reg <= b2_reg;
              b2_reg <= b3_reg;
              phase_reg <= 1'b1;
              state_reg <= TWEEP_BITS;
            end
          end
        TWEEP_STOP:
          if (tick)
          begin
            if (!scl_reg)
              scl_reg <= 1'b1;
            else
            begin
              sda_oe_reg <= 1'b0; // STOP: SDA rises with SCL high
              state_reg <= TWEEP_DONE;
            end
          end
        TWEEP_DONE:
          if (tick)
          begin
            cmd_ready <= 1'b1;
            state_reg <= TWEEP_IDLE;
          end
        default:
          state_reg <= TWEEP_IDLE;
      endcase
  end

  assign link.scl = scl_reg;
  assign link.sda_host_oe = sda_oe_reg;
endmodule

// >>> tweep_link_if.sv
// Two-wire link between the controller end and the memory end
interface tweep_link_if;
  logic scl;
  logic sda_dev_oe;
  logic sda_host_oe;
  logic sda_in;
  // Open-drain wired-AND of both ends, pulled up when nobody drives
  assign sda_in = !(sda_dev_oe || sda_host_oe);
  modport device (input scl, input sda_in, output sda_dev_oe);
  modport host (output scl, input sda_in, output sda_host_oe);
endinterface

// >>> tweep_pkg.sv
// Package of constants and types shared by both ends of the two-wire link
package tweep_pkg;
  localparam int TWEEP_ADDR_W = 17;
  localparam int TWEEP_PAGE_W = 8;
  // Memory-class code; the value is arbitrary
  localparam logic [3:0] TWEEP_CLASS_CODE = 4'h6;
  localparam int TWEEP_CLASS_POS = 4;
  localparam int TWEEP_SEL_UPPER_POS = 3;
  localparam int TWEEP_SEL_LOWER_POS = 2;
  localparam int TWEEP_PAGE_SEL_POS = 1;
  localparam int TWEEP_RW_POS = 0;
  localparam int TWEEP_SYS_CLK_NS = 40;
  localparam int TWEEP_PROG_TIME_MS = 5;
  localparam int TWEEP_PROG_CYCLES =
    TWEEP_PROG_TIME_MS * 1000000 / TWEEP_SYS_CLK_NS;
  localparam int TWEEP_SCL_HALF = 4;
  localparam logic [7:0] TWEEP_ERASED = 8'hFF;
  typedef logic [TWEEP_ADDR_W-1:0] tweep_addr_t;
  typedef enum logic [2:0]
  {
    TWEEP_IDLE = 3'b000,
    TWEEP_START = 3'b001,
    TWEEP_BITS = 3'b011,
    TWEEP_ACK = 3'b010,
    TWEEP_STOP = 3'b110,
    TWEEP_DONE = 3'b111
  } tweep_host_e;
endpackage

// >>> tweep_tb.sv
// Self-checking bench joining controller and memory ends over the link
module tweep_tb
  import tweep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PROG = 200;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sel_hi = 1'b0, sel_lo = 1'b0, wp = 1'b0, cmd_valid = 1'b0;
  logic [7:0] cmd_dev = 8'h00, cmd_data = 8'h00;
  logic [15:0] cmd_addr = 16'h0000, busy_len = 16'h0000;
  logic [1:0] cmd_len = 2'h0;
  logic cmd_ready, cmd_nack, busy, addressed;
  int err_count = 0, num_checks = 0;
  tweep_link_if link();
  always #20 sys_clk = ~sys_clk;
  tweep_device #(.PROG_CYCLES(PROG)) i_tweep_device (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .link(link), .chip_select_upper_pin(sel_hi),
    .chip_select_lower_pin(sel_lo), .write_protect(wp), .busy(busy),
    .addressed(addressed));
  tweep_host i_tweep_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .link(link), .cmd_valid(cmd_valid), .cmd_dev(cmd_dev),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_len(cmd_len),
    .cmd_ready(cmd_ready), .cmd_nack(cmd_nack));
  tweep_chk i_tweep_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .scl(link.scl), .sda_dev_oe(link.sda_dev_oe),
    .sda_host_oe(link.sda_host_oe), .sda_in(link.sda_in));
  // Busy cycles since the last command was issued
  always @(posedge sys_clk)
    if (busy === 1'b1)
      busy_len <= busy_len + 16'h0001;
  task automatic complete_run();
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] act, input logic [15:0] exp);
    num_checks++;
    if (act !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  // One command, entered at a falling edge; waits for the STOP to finish
  task automatic send(input logic [7:0] dev, input logic [1:0] len,
    input logic [15:0] addr, output logic nack);
    int i;
    cmd_dev = dev;
    cmd_len = len;
    cmd_addr = addr;
    cmd_data = addr[7:0] ^ 8'h5A;
    busy_len = 16'h0000;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 3000 && cmd_ready !== 1'b1; i++)
      @(negedge sys_clk);
    if (cmd_ready !== 1'b1)
    begin
      err_count++;
      complete_run();
    end
    nack = cmd_nack;
  endtask
  // Every pin setting against every select field, plus a foreign class
  task automatic sc_select();
    logic nk;
    for (int p = 0; p < 4; p++)
    begin
      {sel_hi, sel_lo} = 2'(p);
      for (int s = 0; s < 4; s++)
      begin
        send({TWEEP_CLASS_CODE, 2'(s), 2'b00}, 2'h0, 16'h0000, nk);
        check({15'h0000, nk}, {15'h0000, s != p});
        check(busy_len, 16'h0000);
      end
      send({~TWEEP_CLASS_CODE, 2'(p), 2'b00}, 2'h0, 16'h0000, nk);
      check({15'h0000, nk}, 16'h0001);
    end
    sel_hi = 1'b1;
    sel_lo = 1'b0;
  endtask
  // Byte write at the page edge, then polls until the device answers
  task automatic sc_byte_write();
    logic nk, first;
    logic [15:0] run;
    send({TWEEP_CLASS_CODE, 4'hA}, 2'h3, 16'h12FF, nk);
    check({15'h0000, nk}, 16'h0000);
    send({TWEEP_CLASS_CODE, 4'hA}, 2'h0, 16'h0000, first);
    run = busy_len;
    check({15'h0000, first}, 16'h0001);
    nk = first;
    for (int n = 0; n < 20 && nk !== 1'b0; n++)
    begin
      send({TWEEP_CLASS_CODE, 4'hA}, 2'h0, 16'h0000, nk);
      run = run + busy_len;
    end
    check({15'h0000, nk}, 16'h0000);
    check({15'h0000, busy}, 16'h0000);
    check({14'h0000, run >= 16'(PROG - 100), run <= 16'(PROG)}, 16'h0003);
    send({TWEEP_CLASS_CODE, 4'hA}, 2'h2, 16'h0040, nk);
    check({15'h0000, nk}, 16'h0000);
    check(busy_len, 16'h0000);
  endtask
  // Protected write is acknowledged but starts no programming
  task automatic sc_protect();
    logic nk;
    wp = 1'b1;
    send({TWEEP_CLASS_CODE, 4'h8}, 2'h3, 16'h0107, nk);
    check({15'h0000, nk}, 16'h0000);
    check(busy_len, 16'h0000);
    send({TWEEP_CLASS_CODE, 4'h8}, 2'h0, 16'h0000, nk);
    check({15'h0000, nk}, 16'h0000);
    wp = 1'b0;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    sc_select();
    sc_byte_write();
    sc_protect();
    complete_run();
  end
endmodule
